// File: rtl/sac_defines.svh
// constants for the converter control block: offsets, field positions, resets, counts
// assumes a 32-bit ahb-lite slave port and a 10 mhz core clock
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ----------------------------------------
// register word indices, matched against HADDR[4:2]
// ----------------------------------------
`define SAC_OFF_CTRL_A     3'h0
`define SAC_OFF_CTRL_B     3'h1
`define SAC_OFF_INPUT_SEL  3'h2
`define SAC_OFF_DATA       3'h3
`define SAC_OFF_IRQ_STAT   3'h4
`define SAC_OFF_IRQ_MASK   3'h5
`define SAC_OFF_STATUS     3'h6

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define SAC_CTRL_A_W       6
`define SAC_CTRL_B_W       4
`define SAC_INPUT_SEL_W    6
`define SAC_IRQ_W          2
`define SAC_IRQ_DONE_BIT   0
`define SAC_IRQ_LOST_BIT   1
`define SAC_LEFT_PAD       6
`define SAC_RESULT_W       10

// ----------------------------------------
// reset values
// ----------------------------------------
`define SAC_CTRL_A_RST     6'h00
`define SAC_CTRL_B_RST     4'h0
`define SAC_INPUT_SEL_RST  6'h00
`define SAC_IRQ_RST        2'h0

// ----------------------------------------
// timing counts, in converter clock cycles except SAC_TRIG_SYNC and SAC_PRE_BASE in core cycles, plus the differential negative input SAC_CMP_DIFF_NEG
// ----------------------------------------
`define SAC_NORMAL_CYCLES  13
`define SAC_FIRST_CYCLES   25
`define SAC_HOLD_NORMAL    1
`define SAC_HOLD_FIRST     13
`define SAC_TRIG_HOLD      2
`define SAC_TRIG_SYNC      3
`define SAC_PRE_BASE       10'h008
`define SAC_CMP_DIFF_NEG   3'h1

`endif

// File: rtl/sac_pkg.sv
// types shared by the converter control block
// assumes sac_defines.svh is on the include path
package sac_pkg;

	typedef enum logic {
		ST_IDLE,
		ST_CONV
	} sac_state_e;

	typedef struct packed {
		logic [2:0] prescale;
		logic auto_trig;
		logic start;
		logic enable;
	} sac_ctrl_a_s;

	typedef struct packed {
		logic [2:0] trig_src;
		logic cmp_mux_en;
	} sac_ctrl_b_s;

	typedef struct packed {
		logic left_adj;
		logic [4:0] chan;
	} sac_input_sel_s;

	typedef struct packed {
		logic [2:0] pos_sel;
		logic [2:0] neg_sel;
		logic diff_mode;
		logic [1:0] gain_sel;
	} sac_mux_s;

endpackage

// File: rtl/sac_conv_ctrl.sv
// control logic of a 10-bit successive-approximation converter with ahb-lite registers
// assumes the analog core follows the trial code and reports COMP_HI asynchronously,
// and that TRIG_IN comes from logic clocked by CORE_CLK
//
// Notes on behaviour
// - mux enabled, converter off: channel drives comparator
// - otherwise alternate pin drives comparator negative
// - start bit begins at next converter edge
// - normal conversion lasts thirteen converter cycles
// - first conversion after enable lasts twenty-five
// - hold at 1.5 or 13.5 cycles
// - completion stores result and sets done flag
// - single mode clears start bit at completion
// - trigger event resets the converter prescaler
// - auto-trigger hold two cycles after edge
// - three core cycles of trigger synchronisation
// - free running restarts, start bit stays set
// - successive approximation yields ten result bits
// - eight single-ended inputs referenced to ground
// - two gain pairs offer 1x, 10x, 200x
// - eight differential channels share negative input one
// - optional left-adjusted result readout
// - completion can raise an interrupt
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`include "sac_defines.svh"

module sac_conv_ctrl
	import sac_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic COMP_HI,
	input wire logic [7:0] TRIG_IN,
	output logic IRQ,
	output logic SAMPLE_HOLD,
	output logic CONV_ACTIVE,
	output logic [9:0] SAR_TRIAL,
	output logic [2:0] MUX_POS_SEL,
	output logic [2:0] MUX_NEG_SEL,
	output logic MUX_DIFF_MODE,
	output logic [1:0] MUX_GAIN_SEL,
	output logic CMP_NEG_ALT,
	output logic [2:0] CMP_NEG_PIN
);

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	sac_ctrl_a_s ctrl_a_reg, ctrl_a_next;
	sac_ctrl_b_s ctrl_b_reg;
	sac_input_sel_s in_sel_reg;
	sac_state_e state_reg, state_next;
	sac_mux_s mux_dec;
	logic [`SAC_IRQ_W-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg;
	logic [9:0] result_reg;
	logic [9:0] pre_cnt_reg;
	logic [4:0] cyc_cnt_reg;
	logic first_pend_reg, first_reg, trig_mode_reg;
	logic sar_act_reg;
	logic [3:0] bit_idx_reg;
	logic [9:0] trial_reg;
	logic cmp_sync1_reg, cmp_sync2_reg;
	logic trig_prev_reg;
	logic [`SAC_TRIG_SYNC-1:0] trig_dly_reg;
	logic wr_pend_reg;
	logic [2:0] wr_idx_reg;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire addr_phase = HSEL & HTRANS[1] & HREADY;
	wire [2:0] a_idx = HADDR[4:2];
	wire a_mapped = (HADDR[11:5] == 7'h00) && (a_idx != 3'h7);
	wire wr_a = wr_pend_reg && (wr_idx_reg == `SAC_OFF_CTRL_A);
	wire wr_b = wr_pend_reg && (wr_idx_reg == `SAC_OFF_CTRL_B);
	wire wr_sel = wr_pend_reg && (wr_idx_reg == `SAC_OFF_INPUT_SEL);
	wire wr_stat = wr_pend_reg && (wr_idx_reg == `SAC_OFF_IRQ_STAT);
	wire wr_mask = wr_pend_reg && (wr_idx_reg == `SAC_OFF_IRQ_MASK);
	wire sac_ctrl_a_s wdat_a = sac_ctrl_a_s'(HWDATA[`SAC_CTRL_A_W-1:0]);

	// ----------------------------------------
	// converter clock enable
	// ----------------------------------------
	// divide by 8 << prescale: the comparator sync needs three core cycles per half period
	wire [10:0] div_full = 11'({1'b0, `SAC_PRE_BASE} << ctrl_a_reg.prescale);
	wire [9:0] div_m1 = 10'(div_full - 11'h001);
	wire [9:0] half_m1 = 10'((div_full >> 1) - 11'h001);
	wire conv_on = ctrl_a_reg.enable;
	wire adc_tick = conv_on && (pre_cnt_reg == div_m1);
	wire adc_half = conv_on && (pre_cnt_reg == half_m1);

	// ----------------------------------------
	// auto trigger path
	// ----------------------------------------
	wire free_run = ctrl_a_reg.auto_trig && (ctrl_b_reg.trig_src == 3'h0);
	wire ext_trig = ctrl_a_reg.auto_trig && (ctrl_b_reg.trig_src != 3'h0);
	wire trig_lvl = TRIG_IN[ctrl_b_reg.trig_src];
	wire trig_edge = trig_lvl & ~trig_prev_reg;
	wire trig_fire = ext_trig && conv_on && trig_dly_reg[`SAC_TRIG_SYNC-1];
	wire trig_take = trig_fire && (state_reg == ST_IDLE);
	wire trig_lost = trig_fire && (state_reg == ST_CONV);

	// ----------------------------------------
	// conversion sequencing
	// ----------------------------------------
	wire [4:0] last_cyc = first_reg ? 5'(`SAC_FIRST_CYCLES - 1) :
		5'(`SAC_NORMAL_CYCLES - 1);
	wire in_conv = (state_reg == ST_CONV);
	wire conv_done = in_conv && adc_tick && (cyc_cnt_reg == last_cyc);
	wire sw_start = (state_reg == ST_IDLE) && conv_on && ctrl_a_reg.start && adc_tick;
	wire conv_start = sw_start || trig_take || (conv_done && free_run);
	wire hold_first = first_reg && adc_half && (cyc_cnt_reg == 5'(`SAC_HOLD_FIRST));
	wire hold_norm = !first_reg && !trig_mode_reg && adc_half &&
		(cyc_cnt_reg == 5'(`SAC_HOLD_NORMAL));
	wire hold_trig = !first_reg && trig_mode_reg && adc_tick &&
		(cyc_cnt_reg == 5'(`SAC_TRIG_HOLD - 1));
	wire hold_now = in_conv && (hold_first || hold_norm || hold_trig);
	wire sar_step = sar_act_reg && adc_tick;
	wire [9:0] bit_mask = 10'h001 << bit_idx_reg;
	wire [9:0] low_mask = bit_mask >> 1;
	// comparator high means the trial code is above the held input: drop that bit
	wire [9:0] trial_kept = cmp_sync2_reg ? (trial_reg & ~bit_mask) : trial_reg;

	always_comb begin
		state_next = state_reg;
		if (!conv_on) begin
			state_next = ST_IDLE;
		end else if (conv_start) begin
			state_next = ST_CONV;
		end else if (conv_done) begin
			state_next = ST_IDLE;
		end
	end

	// start bit: software sets, hardware clears at end of a single conversion
	always_comb begin
		ctrl_a_next = ctrl_a_reg;
		if (conv_done && !free_run) begin
			ctrl_a_next.start = 1'b0;
		end
		if (trig_take) begin
			ctrl_a_next.start = 1'b1;
		end
		if (!conv_on) begin
			ctrl_a_next.start = 1'b0;
		end
		if (wr_a) begin
			ctrl_a_next.prescale = wdat_a.prescale;
			ctrl_a_next.auto_trig = wdat_a.auto_trig;
			ctrl_a_next.enable = wdat_a.enable;
			ctrl_a_next.start = ctrl_a_next.start | (wdat_a.start & wdat_a.enable);
		end
	end

	// ----------------------------------------
	// input multiplexer decode
	// ----------------------------------------
	// chan 0-7 single ended, 8-15 against input one, 16-31 gain pairs
	wire [2:0] ch_low = in_sel_reg.chan[2:0];
	wire is_single = (in_sel_reg.chan[4:3] == 2'b00);
	wire is_common = (in_sel_reg.chan[4:3] == 2'b01);
	wire [1:0] pair_gain = (ch_low[2:1] == 2'b11) ? 2'b00 : ch_low[2:1];

	always_comb begin
		mux_dec.pos_sel = ch_low;
		mux_dec.neg_sel = 3'h0;
		mux_dec.diff_mode = 1'b0;
		mux_dec.gain_sel = 2'b00;
		if (is_common) begin
			mux_dec.neg_sel = `SAC_CMP_DIFF_NEG;
			mux_dec.diff_mode = 1'b1;
		end else if (!is_single) begin
			mux_dec.pos_sel = {1'b0, ch_low[0], 1'b0};
			mux_dec.neg_sel = {1'b0, ch_low[0], 1'b1};
			mux_dec.diff_mode = 1'b1;
			mux_dec.gain_sel = pair_gain;
		end
	end

	wire cmp_use_alt = !ctrl_b_reg.cmp_mux_en || conv_on;

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	wire [`SAC_IRQ_W-1:0] irq_events = {trig_lost, conv_done};
	wire [`SAC_IRQ_W-1:0] irq_w1c = wr_stat ? HWDATA[`SAC_IRQ_W-1:0] : `SAC_IRQ_RST;

	// a new event wins over a clear in the same cycle
	assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_events;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	wire [31:0] data_right = {22'h0, result_reg};
	wire [31:0] data_left = {16'h0000, result_reg, {`SAC_LEFT_PAD{1'b0}}};
	wire [31:0] data_word = in_sel_reg.left_adj ? data_left : data_right;
	logic [31:0] rd_word;

	always_comb begin
		rd_word = 32'h00000000;
		if (a_mapped) begin
			unique case (a_idx)
				`SAC_OFF_CTRL_A: rd_word = {26'h0, ctrl_a_reg};
				`SAC_OFF_CTRL_B: rd_word = {28'h0, ctrl_b_reg};
				`SAC_OFF_INPUT_SEL: rd_word = {26'h0, in_sel_reg};
				`SAC_OFF_DATA: rd_word = data_word;
				`SAC_OFF_IRQ_STAT: rd_word = {30'h0, irq_stat_reg};
				`SAC_OFF_IRQ_MASK: rd_word = {30'h0, irq_mask_reg};
				`SAC_OFF_STATUS: rd_word = {29'h0, first_pend_reg, sar_act_reg, in_conv};
				default: rd_word = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	// zero wait states: read data is captured in the address phase
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 3'h0;
			HRDATA <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			wr_pend_reg <= addr_phase && HWRITE && a_mapped;
			wr_idx_reg <= a_idx;
			HRDATA <= (addr_phase && !HWRITE) ? rd_word : 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			ctrl_a_reg <= sac_ctrl_a_s'(`SAC_CTRL_A_RST);
			ctrl_b_reg <= sac_ctrl_b_s'(`SAC_CTRL_B_RST);
			in_sel_reg <= sac_input_sel_s'(`SAC_INPUT_SEL_RST);
			irq_mask_reg <= `SAC_IRQ_RST;
			irq_stat_reg <= `SAC_IRQ_RST;
		end else begin
			ctrl_a_reg <= ctrl_a_next;
			if (wr_b) begin
				ctrl_b_reg <= sac_ctrl_b_s'(HWDATA[`SAC_CTRL_B_W-1:0]);
			end
			if (wr_sel) begin
				in_sel_reg <= sac_input_sel_s'(HWDATA[`SAC_INPUT_SEL_W-1:0]);
			end
			if (wr_mask) begin
				irq_mask_reg <= HWDATA[`SAC_IRQ_W-1:0];
			end
			irq_stat_reg <= irq_stat_next;
		end
	end

	// ----------------------------------------
	// prescaler and trigger pipeline
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			pre_cnt_reg <= 10'h000;
			trig_prev_reg <= 1'b0;
			trig_dly_reg <= '0;
		end else begin
			if (!conv_on || trig_take || adc_tick) begin
				pre_cnt_reg <= 10'h000;
			end else begin
				pre_cnt_reg <= 10'(pre_cnt_reg + 10'h001);
			end
			trig_prev_reg <= trig_lvl;
			trig_dly_reg <= {trig_dly_reg[`SAC_TRIG_SYNC-2:0], trig_edge};
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			state_reg <= ST_IDLE;
			cyc_cnt_reg <= 5'h00;
			first_pend_reg <= 1'b1;
			first_reg <= 1'b0;
			trig_mode_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (!conv_on) begin
				first_pend_reg <= 1'b1;
			end else if (conv_start) begin
				first_pend_reg <= 1'b0;
			end
			if (conv_start) begin
				cyc_cnt_reg <= 5'h00;
				first_reg <= first_pend_reg && !conv_done;
				trig_mode_reg <= trig_take;
			end else if (in_conv && adc_tick) begin
				cyc_cnt_reg <= 5'(cyc_cnt_reg + 5'h01);
			end
		end
	end

	// ----------------------------------------
	// successive approximation
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			cmp_sync1_reg <= 1'b0;
			cmp_sync2_reg <= 1'b0;
			sar_act_reg <= 1'b0;
			bit_idx_reg <= 4'h0;
			trial_reg <= 10'h000;
			result_reg <= 10'h000;
		end else begin
			cmp_sync1_reg <= COMP_HI;
			cmp_sync2_reg <= cmp_sync1_reg;
			if (!conv_on) begin
				sar_act_reg <= 1'b0;
			end else if (hold_now) begin
				sar_act_reg <= 1'b1;
				bit_idx_reg <= 4'h9;
				trial_reg <= 10'h200;
			end else if (sar_step) begin
				trial_reg <= trial_kept | low_mask;
				bit_idx_reg <= 4'(bit_idx_reg - 4'h1);
				sar_act_reg <= (bit_idx_reg != 4'h0);
			end
			if (conv_done) begin
				result_reg <= trial_reg;
			end
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			IRQ <= 1'b0;
			SAMPLE_HOLD <= 1'b0;
			CONV_ACTIVE <= 1'b0;
			SAR_TRIAL <= 10'h000;
			MUX_POS_SEL <= 3'h0;
			MUX_NEG_SEL <= 3'h0;
			MUX_DIFF_MODE <= 1'b0;
			MUX_GAIN_SEL <= 2'b00;
			CMP_NEG_ALT <= 1'b1;
			CMP_NEG_PIN <= 3'h0;
		end else begin
			IRQ <= |(irq_stat_next & irq_mask_reg);
			SAMPLE_HOLD <= hold_now;
			CONV_ACTIVE <= (state_next == ST_CONV);
			SAR_TRIAL <= trial_reg;
			MUX_POS_SEL <= mux_dec.pos_sel;
			MUX_NEG_SEL <= mux_dec.neg_sel;
			MUX_DIFF_MODE <= mux_dec.diff_mode;
			MUX_GAIN_SEL <= mux_dec.gain_sel;
			CMP_NEG_ALT <= cmp_use_alt;
			CMP_NEG_PIN <= cmp_use_alt ? 3'h0 : ch_low;
		end
	end

endmodule

// File: tb/sac_analog_model.sv
// behavioural sample-and-hold and comparator standing behind the control block
// assumes the hold pulse lasts one core cycle and vin is steady around it
module sac_analog_model (
	input wire logic clk,
	input wire logic sample,
	input wire logic [9:0] trial,
	input wire logic [9:0] vin,
	output logic comp_hi
);
	timeunit 1ns;
	timeprecision 1ns;
	// input is measured against ground, so the held code is the whole answer
	logic [9:0] held = 10'h000;
	always @(posedge clk) begin
		if (sample)
			held <= vin;
	end
	// answers at once; the block's own synchroniser takes care of timing
	assign comp_hi = trial > held;
endmodule

// File: tb/sac_monitor.sv
// port checker for the converter control block
// assumes one clock domain and a synchronous active-high reset
module sac_monitor (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic SAMPLE_HOLD,
	input wire logic CONV_ACTIVE,
	input wire logic [1:0] MUX_GAIN_SEL,
	input wire logic CMP_NEG_ALT,
	input wire logic [2:0] CMP_NEG_PIN
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	// free running keeps activity high across conversions, so holds are spaced, not counted
	logic [6:0] gap;
	logic seen;
	always_ff @(posedge CORE_CLK) begin
		if (RESET || !CONV_ACTIVE) begin
			gap <= 7'h00;
			seen <= 1'b0;
		end else if (SAMPLE_HOLD) begin
			gap <= 7'h00;
			seen <= 1'b1;
		end else if (gap != 7'h7f) begin
			gap <= gap + 7'h01;
		end
	end
	AST_ZERO_WAIT: assert property (HREADYOUT) else $error("wait state inserted");
	AST_OKAY: assert property (!HRESP) else $error("error response given");
	AST_RDATA_IDLE: assert property (!(HSEL && HTRANS[1] && !HWRITE && HREADY) |=>
		HRDATA == 32'h0) else $error("read data outside read phase");
	AST_HOLD_PULSE: assert property (SAMPLE_HOLD |=> !SAMPLE_HOLD)
		else $error("hold pulse too long");
	AST_HOLD_IN_CONV: assert property (SAMPLE_HOLD |-> CONV_ACTIVE)
		else $error("hold outside conversion");
	AST_ONE_HOLD: assert property (SAMPLE_HOLD && seen |-> gap >= 7'h64)
		else $error("second hold inside one conversion");
	AST_HOLD_SEEN: assert property ($fell(CONV_ACTIVE) |-> seen)
		else $error("conversion ended without hold");
	AST_ALT_IDLE: assert property (!CMP_NEG_ALT |-> !CONV_ACTIVE)
		else $error("pin routed while converting");
	AST_PIN_ZERO: assert property (CMP_NEG_ALT |-> CMP_NEG_PIN == 3'h0)
		else $error("pin select with alternate input");
	AST_GAIN: assert property (MUX_GAIN_SEL != 2'h3)
		else $error("undefined gain");
	cover property ($fell(CONV_ACTIVE));
	cover property (SAMPLE_HOLD);
	cover property (!CMP_NEG_ALT);
endmodule

bind sac_conv_ctrl sac_monitor mon (.CORE_CLK(CORE_CLK), .RESET(RESET), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .SAMPLE_HOLD(SAMPLE_HOLD),
	.CONV_ACTIVE(CONV_ACTIVE), .MUX_GAIN_SEL(MUX_GAIN_SEL), .CMP_NEG_ALT(CMP_NEG_ALT),
	.CMP_NEG_PIN(CMP_NEG_PIN));

// File: tb/tb.sv
// self-checking bench for the converter control block
// assumes prescale 0, so one converter cycle is eight core cycles
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, q;
	logic [7:0] trig = 8'h00;
	logic [9:0] vin = 10'h000;
	logic [9:0] sar_trial;
	logic hreadyout, hresp, irq, sample_hold, conv_active, comp_hi, cmp_neg_alt;
	logic [2:0] cmp_neg_pin, mux_pos, mux_neg;
	logic [1:0] mux_gain;
	logic mux_diff;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int st, sh, len;
	always #50 clk = ~clk;
	sac_conv_ctrl uut (.CORE_CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.COMP_HI(comp_hi), .TRIG_IN(trig), .IRQ(irq), .SAMPLE_HOLD(sample_hold),
		.CONV_ACTIVE(conv_active), .SAR_TRIAL(sar_trial), .MUX_POS_SEL(mux_pos),
		.MUX_NEG_SEL(mux_neg), .MUX_DIFF_MODE(mux_diff), .MUX_GAIN_SEL(mux_gain),
		.CMP_NEG_ALT(cmp_neg_alt),
		.CMP_NEG_PIN(cmp_neg_pin));
	sac_analog_model ana (.clk(clk), .sample(sample_hold), .trial(sar_trial), .vin(vin),
		.comp_hi(comp_hi));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rng(input string what, input int lo, input int hi, input int got);
		num_checks++;
		if (got < lo || got > hi) begin
			errors++;
			$display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	// one single transfer; entered and left just after a rising edge
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// start counted from the call, hold and length from the rise of conversion activity, all in core cycles
	task automatic conv;
		st = 0;
		sh = -1;
		len = 0;
		while (conv_active !== 1'b1 && st < 300) begin
			@(posedge clk);
			st++;
		end
		while (conv_active === 1'b1 && len < 300) begin
			if (sample_hold === 1'b1 && sh < 0)
				sh = len;
			@(posedge clk);
			len++;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_mux;
		chk("alt after reset", 32'h1, {31'h0, cmp_neg_alt});
		xfer(1'b1, 32'h1c, 32'hffffffff);
		xfer(1'b0, 32'h1c, 32'h0);
		chk("unmapped", 32'h0, q);
		xfer(1'b1, 32'h04, 32'h1);
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, 32'h08, i);
			cyc(2);
			chk("alt", 32'h0, {31'h0, cmp_neg_alt});
			chk("pin", i, {29'h0, cmp_neg_pin});
			chk("mux single", {29'h0, i[2:0]}, {23'h0, mux_diff, mux_gain, mux_neg, mux_pos});
		end
		xfer(1'b1, 32'h08, 32'h0d);
		cyc(2);
		chk("mux common", {23'h0, 1'b1, 2'h0, 3'h1, 3'h5},
			{23'h0, mux_diff, mux_gain, mux_neg, mux_pos});
		xfer(1'b1, 32'h08, 32'h13);
		cyc(2);
		chk("mux gain", {23'h0, 1'b1, 2'h1, 3'h3, 3'h2},
			{23'h0, mux_diff, mux_gain, mux_neg, mux_pos});
		xfer(1'b1, 32'h00, 32'h1);
		cyc(2);
		chk("alt when on", 32'h1, {31'h0, cmp_neg_alt});
		xfer(1'b1, 32'h00, 32'h0);
		xfer(1'b1, 32'h04, 32'h0);
		cyc(2);
		chk("alt mux off", 32'h1, {31'h0, cmp_neg_alt});
		$display("test mux done");
	endtask
	task automatic t_single;
		xfer(1'b1, 32'h14, 32'h1);
		xfer(1'b1, 32'h08, 32'h0);
		xfer(1'b1, 32'h00, 32'h1);
		vin <= 10'h2a5;
		xfer(1'b1, 32'h00, 32'h3);
		conv;
		rng("start delay", 0, 10, st);
		rng("first hold", 106, 110, sh);
		rng("first length", 192, 201, len);
		cyc(2);
		chk("irq", 32'h1, {31'h0, irq});
		xfer(1'b0, 32'h00, 32'h0);
		chk("start cleared", 32'h1, q);
		xfer(1'b0, 32'h0c, 32'h0);
		chk("result", 32'h2a5, q);
		xfer(1'b0, 32'h10, 32'h0);
		chk("done flag", 32'h1, q);
		xfer(1'b1, 32'h14, 32'h0);
		cyc(2);
		chk("irq masked", 32'h0, {31'h0, irq});
		xfer(1'b1, 32'h10, 32'h1);
		xfer(1'b1, 32'h14, 32'h1);
		cyc(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		xfer(1'b1, 32'h08, 32'h20);
		vin <= 10'h0ff;
		xfer(1'b1, 32'h00, 32'h3);
		conv;
		rng("hold", 10, 14, sh);
		rng("length", 96, 105, len);
		xfer(1'b0, 32'h0c, 32'h0);
		chk("left result", 32'h3fc0, q);
		xfer(1'b1, 32'h10, 32'h1);
		$display("test single done");
	endtask
	task automatic t_trig;
		xfer(1'b1, 32'h08, 32'h0);
		xfer(1'b1, 32'h04, 32'h6);
		xfer(1'b1, 32'h00, 32'h5);
		vin <= 10'h155;
		trig <= 8'h20;
		cyc(4);
		trig <= 8'h00;
		cyc(40);
		chk("unselected trigger", 32'h0, {31'h0, conv_active});
		trig <= 8'h08;
		st = 0;
		do begin
			@(posedge clk);
			st++;
		end while (sample_hold !== 1'b1 && st < 100);
		trig <= 8'h00;
		rng("trigger to hold", 16, 22, st);
		cyc(2);
		trig <= 8'h08;
		cyc(2);
		trig <= 8'h00;
		conv;
		xfer(1'b0, 32'h0c, 32'h0);
		chk("trig result", 32'h155, q);
		xfer(1'b0, 32'h10, 32'h0);
		chk("trigger lost", 32'h3, q);
		xfer(1'b1, 32'h10, 32'h3);
		$display("test trigger done");
	endtask
	task automatic t_free;
		xfer(1'b1, 32'h04, 32'h0);
		xfer(1'b1, 32'h00, 32'h7);
		cyc(230);
		xfer(1'b0, 32'h00, 32'h0);
		chk("start kept", 32'h7, q);
		xfer(1'b1, 32'h10, 32'h1);
		cyc(110);
		xfer(1'b0, 32'h10, 32'h0);
		chk("restarted", 32'h1, q & 32'h1);
		xfer(1'b1, 32'h00, 32'h0);
		$display("test free done");
	endtask
	// ----------------------------------------
	// main sequence and hang guard
	// ----------------------------------------
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		cyc(16);
		rst <= 1'b0;
		@(posedge clk);
		t_mux();
		t_single();
		t_trig();
		t_free();
		final_report();
	end
endmodule
